/* dv/can_rx_acceptance_filter_tb_top.sv */
// self-checking bench for the receive acceptance filter
`timescale 1ns/10ps
`default_nettype none

module can_rx_acceptance_filter_tb_top;
  // ========================================================================
  // wiring and bookkeeping
  logic                  clk;
  logic                  rst;
  can_rx_pkg::apb_req_t  req;
  logic                  pready_q;
  logic                  pslverr_q;
  logic [31:0]           prdata_q;
  logic                  rx_valid;
  can_rx_pkg::rx_frame_t rx_frame;
  logic                  lost_irq_q;
  logic [32:0]           exp_q[$];
  int                    failures;
  int                    n_checks;
  int                    n_irq;
  integer                seed;
  logic [63:0]           d;

  // free-running 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  can_rx_acceptance_filter u_dut (
    .clk        (clk),
    .rst        (rst),
    .apb_req    (req),
    .pready_q   (pready_q),
    .pslverr_q  (pslverr_q),
    .prdata_q   (prdata_q),
    .rx_valid   (rx_valid),
    .rx_frame   (rx_frame),
    .lost_irq_q (lost_irq_q)
  );

  frame_source u_src (
    .clk      (clk),
    .rx_valid (rx_valid),
    .rx_frame (rx_frame)
  );

  // ========================================================================
  // comparison and closing
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("failures=%0d n_checks=%0d", failures, n_checks);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ========================================================================
  // apb master; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] v);
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= {i, 2'b00};
    req.pwdata  <= v;
    @(posedge clk);
    req.penable <= 1'b1;
    // pready sampled at each rising edge; only the watchdog ends a wait
    do begin
      @(posedge clk);
    end while (pready_q !== 1'b1);
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [13:0] i, input logic [31:0] v);
    apb(1'b1, i, v);
  endtask

  // expected {pslverr, prdata} is noted first, the monitor compares it
  task automatic rd(input logic [13:0] i, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, i, 32'h0);
  endtask

  function automatic logic [13:0] mb(input int n, input int k);
    return can_rx_pkg::IDX_MB_BASE + 14'(4 * n + k);
  endfunction

  // ========================================================================
  // monitor: read completions and interrupt pulses
  always @(posedge clk) begin
    if (pready_q === 1'b1 && req.psel && req.penable && !req.pwrite && exp_q.size() > 0)
      check({pslverr_q, prdata_q}, exp_q.pop_front());
    if (lost_irq_q === 1'b1)
      n_irq++;
  end

  // watchdog, far beyond the expected run of a few hundred cycles
  initial begin
    #200000;
    failures++;
    end_of_test();
  end

  // ========================================================================
  // main sequence
  initial begin
    rst = 1'b1;
    req = '0;
    failures = 0;
    n_checks = 0;
    n_irq = 0;
    seed = 9730;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    // reset values
    for (int i = 0; i < 4; i++)
      rd(can_rx_pkg::IDX_LMASK0_LO + 14'(i), 33'h0);
    rd(can_rx_pkg::IDX_RPEND_LO, 33'h0);
    rd(can_rx_pkg::IDX_RPEND_HI, 33'h0);
    rd(14'h2000, 33'h100000000);
    // setup: boxes 0 and 1 share an extended id, box 2 standard, box 15 local
    wr(can_rx_pkg::IDX_CTRL, 32'h1);
    wr(mb(0, 0), 32'habcd1234);
    wr(mb(1, 0), 32'habcd1234);
    wr(mb(2, 0), 32'h95540000);
    wr(mb(15, 0), 32'hff000000);
    wr(can_rx_pkg::IDX_LMASK1_LO, 32'hff);
    rd(can_rx_pkg::IDX_LMASK1_LO, 33'hff);
    // first store, then overwrite while still pending
    d = {$random(seed), $random(seed)};
    u_src.send(29'h0bcd1234, 1'b1, 1'b0, d);
    rd(can_rx_pkg::IDX_PEND_LO, 33'h01);
    rd(mb(0, 2), {1'b0, d[31:0]});
    d = {$random(seed), $random(seed)};
    u_src.send(29'h0bcd1234, 1'b1, 1'b0, d);
    rd(can_rx_pkg::IDX_LOST_LO, 33'h01);
    rd(mb(0, 3), {1'b0, d[63:32]});
    // clearing: only a 1 into the pending flag clears anything
    wr(can_rx_pkg::IDX_PEND_LO, 32'h0);
    wr(can_rx_pkg::IDX_LOST_LO, 32'hff);
    rd(can_rx_pkg::IDX_PEND_LO, 33'h01);
    rd(can_rx_pkg::IDX_LOST_LO, 33'h01);
    wr(can_rx_pkg::IDX_PEND_LO, 32'h01);
    rd(can_rx_pkg::IDX_LOST_LO, 33'h00);
    rd(can_rx_pkg::IDX_PEND_LO, 33'h00);
    // remote frame into box 2, then a standard data frame overwrites it
    u_src.send(29'h15540000, 1'b0, 1'b1, 64'h0);
    rd(can_rx_pkg::IDX_RPEND_LO, 33'h04);
    rd(can_rx_pkg::IDX_PEND_LO, 33'h04);
    u_src.send(29'h155401ff, 1'b0, 1'b0, d);
    rd(can_rx_pkg::IDX_RPEND_LO, 33'h00);
    rd(can_rx_pkg::IDX_LOST_LO, 33'h04);
    rd(mb(2, 1), 33'h08);
    wr(can_rx_pkg::IDX_PEND_LO, 32'h04);
    u_src.send(29'h15540000, 1'b0, 1'b1, 64'h0);
    wr(can_rx_pkg::IDX_PEND_LO, 32'h0);
    rd(can_rx_pkg::IDX_RPEND_LO, 33'h04);
    wr(can_rx_pkg::IDX_PEND_LO, 32'h04);
    rd(can_rx_pkg::IDX_RPEND_LO, 33'h00);
    // receive-only box with low eight bits masked locally
    u_src.send(29'h1f0000a5, 1'b1, 1'b0, d);
    rd(can_rx_pkg::IDX_PEND_HI, 33'h80);
    // global mask on box 3 catches the frame before box 15 is looked at
    wr(can_rx_pkg::IDX_GMASK, 32'hff);
    wr(mb(3, 0), 32'hff000000);
    u_src.send(29'h1f00005a, 1'b1, 1'b0, d);
    rd(can_rx_pkg::IDX_PEND_LO, 33'h08);
    rd(can_rx_pkg::IDX_LOST_HI, 33'h00);
    // unmasked bit differs, and a standard frame while format bit is 0
    u_src.send(29'h1f0001a5, 1'b1, 1'b0, d);
    u_src.send(29'h1f000000, 1'b0, 1'b0, d);
    rd(can_rx_pkg::IDX_PEND_LO, 33'h08);
    rd(can_rx_pkg::IDX_LOST_HI, 33'h00);
    // format bit set between frames takes effect at once
    wr(can_rx_pkg::IDX_LMASK0_HI, 32'h80);
    u_src.send(29'h1f000000, 1'b0, 1'b0, d);
    rd(can_rx_pkg::IDX_LOST_HI, 33'h80);
    // global format bit, interrupt off: box 3 overruns on a standard frame
    wr(can_rx_pkg::IDX_CTRL, 32'h0);
    wr(can_rx_pkg::IDX_GMASK, 32'h800000ff);
    u_src.send(29'h1f000000, 1'b0, 1'b0, d);
    rd(can_rx_pkg::IDX_LOST_LO, 33'h08);
    rd(can_rx_pkg::IDX_LOST_HI, 33'h80);
    repeat (4) @(posedge clk);
    check(33'(n_irq), 33'd3);
    check(33'(exp_q.size()), 33'd0);
    end_of_test();
  end
endmodule

`default_nettype wire

/* dv/frame_source.sv */
// partner model: protocol engine handing received frames to the filter
`timescale 1ns/10ps
`default_nettype none

module frame_source (
  // clock
  input  wire logic             clk,
  // frame handoff
  output var logic              rx_valid,
  output var can_rx_pkg::rx_frame_t rx_frame
);
  // ========================================================================
  // idle state at time zero
  initial begin
    rx_valid = 1'b0;
    rx_frame = '0;
  end

  // one-cycle strobe carrying a whole frame; afterwards the bus shows the
  // inverse so a stale frame can never pass for a fresh one
  task automatic send(input logic [28:0] id, input logic ide, input logic rtr,
                      input logic [63:0] d);
    can_rx_pkg::rx_frame_t f;
    f = '{id: id, ide: ide, rtr: rtr, dlc: 4'h8, data: d};
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_frame <= f;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_frame <= ~f;
  endtask
endmodule

`default_nettype wire

/* logic/can_rx_acceptance_filter.sv */
// receive acceptance filter, mailbox store and receive flags with apb access
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none

module can_rx_acceptance_filter (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // apb slave
  input  wire can_rx_pkg::apb_req_t  apb_req,
  output logic                       pready_q,
  output logic                       pslverr_q,
  output logic [31:0]                prdata_q,
  // frames from the protocol engine, same clock
  input  wire logic                  rx_valid,
  input  wire can_rx_pkg::rx_frame_t rx_frame,
  // lost-message interrupt pulse
  output logic                       lost_irq_q
);

  can_rx_pkg::state_t q;
  can_rx_pkg::state_t d;

  logic [13:0]                   idx;
  logic                          in_mb;
  logic [3:0]                    mb_sel;
  logic [1:0]                    mb_word;
  logic                          acc;
  logic                          addr_ok;
  logic [31:0]                   rd_data;
  logic [31:0]                   wdat;
  logic [can_rx_pkg::NUM_MB-1:0] hits;
  logic [can_rx_pkg::NUM_MB-1:0] clr_vec;
  logic [can_rx_pkg::NUM_MB-1:0] lost_set;
  logic [3:0]                    win;
  logic                          found;
  logic                          store;

  // ========================================================================
  // address decode
  assign idx     = apb_req.paddr[15:2];
  assign in_mb   = (idx[13:6] == can_rx_pkg::IDX_MB_BASE[13:6]);
  assign mb_sel  = idx[5:2];
  assign mb_word = idx[1:0];
  assign acc     = apb_req.psel & apb_req.penable;
  assign wdat    = apb_req.pwdata;

  // ========================================================================
  // read mux; unmapped reads return zero with an error
  always_comb begin
    rd_data = '0;
    addr_ok = 1'h1;
    if (in_mb) begin
      case (mb_word)
        2'h0: rd_data = q.mb_id[mb_sel];
        2'h1: rd_data = {27'h0, q.mb_ctrl[mb_sel]};
        2'h2: rd_data = q.mb_lo[mb_sel];
        default: rd_data = q.mb_hi[mb_sel];
      endcase
    end else begin
      case (idx)
        can_rx_pkg::IDX_PEND_LO:   rd_data = {24'h0, q.pend[7:0]};
        can_rx_pkg::IDX_PEND_HI:   rd_data = {24'h0, q.pend[15:8]};
        can_rx_pkg::IDX_LOST_LO:   rd_data = {24'h0, q.lost[7:0]};
        can_rx_pkg::IDX_LOST_HI:   rd_data = {24'h0, q.lost[15:8]};
        can_rx_pkg::IDX_RPEND_LO:  rd_data = {24'h0, q.rpend[7:0]};
        can_rx_pkg::IDX_RPEND_HI:  rd_data = {24'h0, q.rpend[15:8]};
        // local mask readback, format bit on top of high byte
        can_rx_pkg::IDX_LMASK0_LO: rd_data = {24'h0, q.lmask[23:16]};
        can_rx_pkg::IDX_LMASK0_HI: rd_data = {24'h0, q.lmask_fmt, 2'h0, q.lmask[28:24]};
        can_rx_pkg::IDX_LMASK1_LO: rd_data = {24'h0, q.lmask[7:0]};
        can_rx_pkg::IDX_LMASK1_HI: rd_data = {24'h0, q.lmask[15:8]};
        can_rx_pkg::IDX_GMASK:     rd_data = {q.gmask_fmt, 2'h0, q.gmask};
        can_rx_pkg::IDX_CTRL:    rd_data = {31'h0, q.irq_en};
        default:                 addr_ok = 1'h0;
      endcase
    end
  end

  // ========================================================================
  // one comparator per mailbox; masks are read live, so a mask changed
  // mid-reception is used by the very next compare
  for (genvar n = 0; n < can_rx_pkg::NUM_MB; n++) begin : g_mb
    logic                        men;
    logic                        en;
    logic [can_rx_pkg::ID_W-1:0] msk;
    logic                        fmt;

    assign men = q.mb_id[n][can_rx_pkg::MB_MEN_BIT];

    if (n == can_rx_pkg::RX_ONLY_MB) begin : g_local
      // receive-only box: local mask alone, global mask never reaches it
      assign msk = men ? q.lmask : '0;
      assign fmt = men & q.lmask_fmt;
      assign en  = rx_valid;
    end else begin : g_global
      assign msk = men ? q.gmask : '0;
      assign fmt = men & q.gmask_fmt;
      // remote frames see every box, data frames only receive boxes
      assign en  = rx_valid & (q.mb_id[n][can_rx_pkg::MB_DIR_BIT] | rx_frame.rtr);
    end

    mailbox_match u_match (
      .frame_id  (rx_frame.id),
      .frame_ide (rx_frame.ide),
      .mb_id     (q.mb_id[n][can_rx_pkg::ID_W-1:0]),
      .mb_ide    (q.mb_id[n][can_rx_pkg::MB_IDE_BIT]),
      .enable    (en),
      .mask      (msk),
      .mask_fmt  (fmt),
      .hit       (hits[n])
    );
  end

  // ========================================================================
  // priority pick: lowest box wins; box 15 only when 0-14 all missed
  always_comb begin
    win   = 4'h0;
    found = 1'h0;
    for (int i = can_rx_pkg::NUM_MB - 1; i >= 0; i--) begin
      if (hits[i]) begin
        win   = 4'(i);
        found = 1'h1;
      end
    end
  end

  // a remote hit on a transmit box stops the search but stores nothing
  assign store = found & ((win == 4'(can_rx_pkg::RX_ONLY_MB))
                          | q.mb_id[win][can_rx_pkg::MB_DIR_BIT]);

  // ========================================================================
  // next state
  always_comb begin
    d        = q;
    clr_vec  = '0;
    lost_set = '0;
    d.irq    = 1'h0;

    // apb: one wait cycle, write commits on the completing edge
    if (acc & q.pready) begin
      d.pready  = 1'h0;
      d.pslverr = 1'h0;
      d.prdata  = '0;
      if (apb_req.pwrite & addr_ok) begin
        if (in_mb) begin
          case (mb_word)
            2'h0: d.mb_id[mb_sel]   = wdat;
            2'h1: d.mb_ctrl[mb_sel] = wdat[4:0];
            2'h2: d.mb_lo[mb_sel]   = wdat;
            default: d.mb_hi[mb_sel] = wdat;
          endcase
        end else begin
          case (idx)
            can_rx_pkg::IDX_PEND_LO: clr_vec[7:0]  = wdat[7:0];
            can_rx_pkg::IDX_PEND_HI: clr_vec[15:8] = wdat[7:0];
            can_rx_pkg::IDX_LMASK0_LO: d.lmask[23:16] = wdat[7:0];
            can_rx_pkg::IDX_LMASK0_HI: begin
              d.lmask_fmt    = wdat[can_rx_pkg::LMASK_FMT_BIT];
              d.lmask[28:24] = wdat[4:0];
            end
            can_rx_pkg::IDX_LMASK1_LO: d.lmask[7:0]  = wdat[7:0];
            can_rx_pkg::IDX_LMASK1_HI: d.lmask[15:8] = wdat[7:0];
            can_rx_pkg::IDX_GMASK: begin
              d.gmask     = wdat[can_rx_pkg::ID_W-1:0];
              d.gmask_fmt = wdat[can_rx_pkg::GMASK_FMT_BIT];
            end
            can_rx_pkg::IDX_CTRL: d.irq_en = wdat[can_rx_pkg::IRQ_EN_BIT];
            // lost and remote-pending writes fall here and do nothing
            default: ;
          endcase
        end
      end
    end else if (acc) begin
      d.pready  = 1'h1;
      d.prdata  = rd_data;
      d.pslverr = ~addr_ok;
    end

    // writing 1 to a pending bit clears pending, lost and remote-pending
    d.pend  = q.pend & ~clr_vec;
    d.lost  = q.lost & ~clr_vec;
    d.rpend = q.rpend & ~clr_vec;

    // store after the clear so a same-cycle arrival is never lost
    if (store) begin
      lost_set[win]   = q.pend[win];
      d.lost[win]     = q.lost[win] | q.pend[win];
      d.pend[win]     = 1'h1;
      d.rpend[win]    = rx_frame.rtr;
      d.mb_id[win][can_rx_pkg::ID_W-1:0]     = rx_frame.id;
      d.mb_id[win][can_rx_pkg::MB_IDE_BIT]   = rx_frame.ide;
      d.mb_ctrl[win]  = {rx_frame.rtr, rx_frame.dlc};
      d.mb_lo[win]    = rx_frame.data[31:0];
      d.mb_hi[win]    = rx_frame.data[63:32];
    end

    // one-cycle interrupt pulse per overrun
    d.irq = q.irq_en & (|lost_set);
  end

  // ========================================================================
  // state register, synchronous reset
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= can_rx_pkg::STATE_RST;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign pready_q   = q.pready;
  assign pslverr_q  = q.pslverr;
  assign prdata_q   = q.prdata;
  assign lost_irq_q = q.irq;

  // ========================================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // access phase entered without a pending answer
  sequence s_acc_start;
    acc && !q.pready;
  endsequence

  // master still holding the request on the next edge
  sequence s_acc_held;
    acc;
  endsequence

  a_apb_one_wait: assert property (s_acc_start ##1 s_acc_held |-> pready_q)
    else $error("apb answer not given after one wait cycle");

  a_lost_on_overrun: assert property (store && q.pend[win] |=> q.lost[$past(win)])
    else $error("overrun did not set lost flag");

  a_lost_no_clear: assert property (!(|clr_vec) |=> ($past(q.lost) & ~q.lost) == 16'h0)
    else $error("lost flag cleared without pending write");

  a_remote_both: assert property (store && rx_frame.rtr
                                  |=> q.pend[$past(win)] && q.rpend[$past(win)])
    else $error("remote frame did not set pending and remote flags");

  a_single_store: assert property (store |=> $countones(q.pend & ~$past(q.pend)) <= 1)
    else $error("frame stored in more than one mailbox");

  a_remote_clear: assert property ((|(clr_vec & q.rpend)) && !store
                                   |=> (q.rpend & $past(clr_vec)) == 16'h0)
    else $error("remote-pending not cleared by pending write");

  a_remote_data_clr: assert property (store && !rx_frame.rtr |=> !q.rpend[$past(win)])
    else $error("data frame left remote-pending set");

  a_mb15_last: assert property (store && win == 4'hf |-> hits[14:0] == 15'h0)
    else $error("mailbox 15 took a frame another mailbox matched");

  a_store_id: assert property (store |=> q.mb_id[$past(win)][28:0] == $past(rx_frame.id)
                               && q.mb_lo[$past(win)] == $past(rx_frame.data[31:0]))
    else $error("stored identifier or data wrong");

  a_no_match: assert property (rx_valid && !store && !(|clr_vec)
                               |=> q.pend == $past(q.pend) && q.rpend == $past(q.rpend))
    else $error("unmatched frame changed flags");

  // the pulse may only last a second cycle when a second overrun caused it
  a_irq_lost: assert property (store && q.pend[win] && q.irq_en
                               |=> lost_irq_q
                               ##1 (!lost_irq_q || $past(store && q.pend[win] && q.irq_en)))
    else $error("lost interrupt not raised");

endmodule

`default_nettype wire

/* logic/can_rx_pkg.sv */
// package: constants, field layout and carriers of the can receive acceptance filter
// ==========================================================================
// Overview of operation
// - Message into a mailbox already pending overwrites it and sets its lost flag.
// - Lost flag set by hardware; cleared only by writing 1 to pending flag.
// - Remote frames are compared against every mailbox, masked per mask-enable bit.
// - Remote frame matching a receive mailbox stores like data; sets pending and remote.
// - Comparison stops at first match; a frame lands in at most one mailbox.
// - Remote-pending clears on writing 1 to that mailbox pending flag; 0 ignored.
// - Remote-pending clears when a data frame overwrites the held remote frame.
// - Mailboxes 0-14 with mask enable use the global mask; first match wins.
// - Mailbox 15 is compared only when no mailbox 0-14 matched.
// - Mailbox 15 uses only the local mask, when its mask enable is set.
// - Mask bit 0 requires equal identifier bit; mask bit 1 is don't-care.
// - Extended: IDE and 29 bits compared; standard: IDE and bits 28-18.
// - Local format bit 0: mailbox 15 accepts only its own IDE format.
// - Local format bit 1: both formats accepted, each on its own bit span; code honours it only while mailbox 15 mask enable is set.
// - Local mask over two registers; format bit at 15; all reset to 0.
// - Bit n of lost and remote-pending flag sets belongs to mailbox n.
// - Pending flag set on store; cleared only by CPU writing 1.
// - On match, identifier, control bits and data bytes go into the mailbox; code stores nothing when a remote frame hits a transmit box.
// - A frame matching no mailbox changes no mailbox and no flag.
// - Setting a lost flag raises the lost interrupt when enabled.
package can_rx_pkg;

  // ========================================================================
  // sizes
  localparam int ID_W       = 29;
  localparam int NUM_MB     = 16;
  localparam int RX_ONLY_MB = 15;
  localparam int STD_LSB    = 18;

  // ========================================================================
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_PEND_LO   = 14'h230c;
  localparam logic [13:0] IDX_PEND_HI   = 14'h230d;
  localparam logic [13:0] IDX_LOST_LO   = 14'h230e;
  localparam logic [13:0] IDX_LOST_HI   = 14'h230f;
  localparam logic [13:0] IDX_LMASK0_LO = 14'h2310;
  localparam logic [13:0] IDX_LMASK0_HI = 14'h2311;
  localparam logic [13:0] IDX_LMASK1_LO = 14'h2312;
  localparam logic [13:0] IDX_LMASK1_HI = 14'h2313;
  localparam logic [13:0] IDX_GMASK     = 14'h2320;
  localparam logic [13:0] IDX_CTRL      = 14'h2330;
  localparam logic [13:0] IDX_RPEND_LO  = 14'h232c;
  localparam logic [13:0] IDX_RPEND_HI  = 14'h232d;
  localparam logic [13:0] IDX_MB_BASE   = 14'h2400;

  // ========================================================================
  // field positions
  localparam int MB_IDE_BIT    = 29;
  localparam int MB_MEN_BIT    = 30;
  localparam int MB_DIR_BIT    = 31;
  localparam int LMASK_FMT_BIT = 7;
  localparam int GMASK_FMT_BIT = 31;
  localparam int IRQ_EN_BIT    = 0;

  // ========================================================================
  // carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [ID_W-1:0] id;
    logic            ide;
    logic            rtr;
    logic [3:0]      dlc;
    logic [63:0]     data;
  } rx_frame_t;

  typedef struct packed {
    logic [ID_W-1:0]              lmask;
    logic                         lmask_fmt;
    logic [ID_W-1:0]              gmask;
    logic                         gmask_fmt;
    logic                         irq_en;
    logic [NUM_MB-1:0]            pend;
    logic [NUM_MB-1:0]            lost;
    logic [NUM_MB-1:0]            rpend;
    logic [NUM_MB-1:0][31:0]      mb_id;
    logic [NUM_MB-1:0][4:0]       mb_ctrl;
    logic [NUM_MB-1:0][31:0]      mb_lo;
    logic [NUM_MB-1:0][31:0]      mb_hi;
    logic                         pready;
    logic                         pslverr;
    logic [31:0]                  prdata;
    logic                         irq;
  } state_t;

  // ========================================================================
  // reset values
  localparam state_t STATE_RST = '0;

endpackage

/* logic/mailbox_match.sv */
// one mailbox identifier comparator with mask and format handling
`timescale 1ns/10ps
`default_nettype none

module mailbox_match (
  // incoming frame
  input  wire logic [can_rx_pkg::ID_W-1:0] frame_id,
  input  wire logic                        frame_ide,
  // mailbox setup
  input  wire logic [can_rx_pkg::ID_W-1:0] mb_id,
  input  wire logic                        mb_ide,
  input  wire logic                        enable,
  // mask in force for this mailbox
  input  wire logic [can_rx_pkg::ID_W-1:0] mask,
  input  wire logic                        mask_fmt,
  // result
  output logic                             hit
);

  logic [can_rx_pkg::ID_W-1:0] diff;
  logic                        fmt_ok;
  logic                        id_ok;

  // ========================================================================
  // masked compare; a set mask bit drops that bit out of the compare
  assign diff   = (frame_id ^ mb_id) & ~mask;
  // format bit masks the ide compare
  assign fmt_ok = mask_fmt | (frame_ide == mb_ide);
  // standard frames only look at the upper eleven bits
  assign id_ok  = frame_ide ? (diff == '0)
                            : (diff[can_rx_pkg::ID_W-1:can_rx_pkg::STD_LSB] == '0);
  assign hit    = enable & fmt_ok & id_ok;

endmodule

`default_nettype wire
